/* rtl/srp_profiler.sv */
`timescale 1ns/1ps
`default_nettype none
module srp_profiler (
    input  wire logic                        ref_clk,      // shared-memory clock
    input  wire logic                        reset,
    input  wire logic                        rd_req,       // read request on port
    input  wire logic                        req_stall,    // request stalled at boundary
    input  wire logic [srp_pkg::BANK_W-1:0]  req_bank,     // bank of request
    input  wire logic                        rd_ack,       // read acknowledge on port
    input  wire logic                        prof_enable,  // software enable
    input  wire logic                        clear_counts, // clear statistics
    input  wire logic [srp_pkg::N_BANKS-1:0] bank_accept,  // per-bank accept bits
    output logic                             trace_event,  // combined event to trace unit
    output logic [srp_pkg::N_EVENTS-1:0]     ws_event,     // per wait-state event
    output logic                             busy,         // a read is being timed
    output logic [srp_pkg::N_EVENTS*srp_pkg::STAT_W-1:0] ws_counts
);
    // port is only sampled; no output reaches it
    // decode: accepted, non-stalled read request
    wire logic req_dec = prof_enable & rd_req & ~req_stall;
    wire logic ack_dec = prof_enable & rd_ack;

    // pending request queue, banks only
    logic [srp_pkg::BANK_W-1:0] bank_q [srp_pkg::DEPTH];
    logic [srp_pkg::PTR_W-1:0]  wr_q, rd_q;
    logic [srp_pkg::PTR_W:0]    fill_q;
    // ack history: true when no timed read is outstanding
    logic                       ack_seen_q;
    // counter state, plus the states that a start or a stop leads to
    srp_pkg::srp_state_e        state_q, state_d;
    srp_pkg::srp_state_e        state_go, after_stop;
    logic [srp_pkg::CNT_W-1:0]  cnt_q;
    logic [srp_pkg::BANK_W-1:0] cur_bank_q;
    logic                       ev_valid_q;
    logic [srp_pkg::CNT_W-1:0]  ev_index_q;
    logic [srp_pkg::BANK_W-1:0] ev_bank_q;

    wire logic q_empty = (fill_q == '0);
    // request available: queued, or decoded right now
    wire logic have_req = ~q_empty | req_dec;
    // previous ack seen: history or arriving this cycle
    wire logic prev_ack = ack_seen_q | ack_dec;
    wire logic start    = have_req & prev_ack;
    // same-cycle decode means queue empty and request arriving now
    wire logic start_same = start & q_empty;
    wire logic [srp_pkg::BANK_W-1:0] start_bank = q_empty ? req_bank : bank_q[rd_q];
    wire logic push = req_dec & ~start_same;
    wire logic pop  = start & ~q_empty;
    wire logic stop = ack_dec & (state_q != srp_pkg::SRP_IDLE);
    wire logic [srp_pkg::CNT_W-1:0] cnt_inc =
        (cnt_q == srp_pkg::CNT_MAX) ? srp_pkg::CNT_MAX : cnt_q + 3'h1;
    // state entered by a start: hold one cycle unless decoded this very cycle
    // the hold keeps the previous read's data cycle out of this count
    assign state_go   = start_same ? srp_pkg::SRP_COUNT : srp_pkg::SRP_HOLD;
    // after a stop: straight into the next queued or just-decoded read, or back to idle
    assign after_stop = start ? state_go : srp_pkg::SRP_IDLE;

    // request queue, oldest first; a fifth request is beyond the port's limit
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wr_q   <= '0;
            rd_q   <= '0;
            fill_q <= '0;
        end else begin
            if (push) begin
                bank_q[wr_q] <= req_bank;
                wr_q         <= wr_q + 2'h1;
            end
            if (pop) begin
                rd_q <= rd_q + 2'h1;
            end
            fill_q <= fill_q + {2'h0, push} - {2'h0, pop};
        end
    end

    // ack history, cleared on start; an ack in the same cycle is consumed by it
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ack_seen_q <= 1'b1;
        end else if (start) begin
            ack_seen_q <= 1'b0;
        end else if (ack_dec) begin
            ack_seen_q <= 1'b1;
        end
    end

    // counter state machine: only one read timed at a time
    always_comb begin
        state_d = state_q;
        case (state_q)
            srp_pkg::SRP_IDLE: begin
                if (start) begin
                    state_d = state_go;
                end
            end
            // hold lasts one cycle; an ack here ends the read at once
            srp_pkg::SRP_HOLD: begin
                state_d = stop ? after_stop : srp_pkg::SRP_COUNT;
            end
            srp_pkg::SRP_COUNT: begin
                if (stop) begin
                    state_d = after_stop;
                end
            end
            default: begin
                state_d = srp_pkg::SRP_IDLE;
            end
        endcase
    end

    // counter in shared-memory clock cycles
    always_ff @(posedge ref_clk) begin
        if (reset || !prof_enable) begin
            state_q <= srp_pkg::SRP_IDLE;
            cnt_q   <= srp_pkg::CNT_ZERO;
        end else begin
            state_q <= state_d;
            if (start && (stop || state_q == srp_pkg::SRP_IDLE)) begin
                cnt_q <= srp_pkg::CNT_ZERO;
            end else if (state_q == srp_pkg::SRP_COUNT && !stop) begin
                cnt_q <= cnt_inc;
            end
        end
    end

    // bank of the read being timed
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cur_bank_q <= '0;
        end else if (start) begin
            cur_bank_q <= start_bank;
        end
    end

    // final count selects event; index equals count, 7 means seven or more
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ev_valid_q <= 1'b0;
            ev_index_q <= '0;
            ev_bank_q  <= '0;
        end else begin
            ev_valid_q <= stop;
            ev_index_q <= cnt_q;
            ev_bank_q  <= cur_bank_q;
        end
    end

    // one-hot event vector and combined trace event
    genvar g;
    generate
        for (g = 0; g < srp_pkg::N_EVENTS; g++) begin : g_ev
            assign ws_event[g] = ev_valid_q && ev_index_q == srp_pkg::CNT_W'(g);
        end
    endgenerate
    assign trace_event = |ws_event;
    assign busy        = (state_q != srp_pkg::SRP_IDLE);

    // filter and statistics counters; an event reaches them one cycle after its stop
    srp_stats u_stats (
        .ref_clk      (ref_clk),
        .reset        (reset),
        .ev_valid     (ev_valid_q),
        .ev_index     (ev_index_q),
        .ev_bank      (ev_bank_q),
        .bank_accept  (bank_accept),
        .clear_counts (clear_counts),
        .ws_counts    (ws_counts)
    );

    // checks
    a_cnt_saturate: assert property (@(posedge ref_clk) disable iff (reset)
        cnt_q == srp_pkg::CNT_MAX && state_q == srp_pkg::SRP_COUNT && !stop
        |=> cnt_q == srp_pkg::CNT_MAX) else $error("count wrapped");
    a_disabled_idle: assert property (@(posedge ref_clk) disable iff (reset)
        !prof_enable |=> !ev_valid_q || $past(stop)) else $error("event while disabled");
    a_stall_ignored: assert property (@(posedge ref_clk) disable iff (reset)
        rd_req && req_stall && q_empty && !ack_seen_q |-> !start) else $error("stall started");
    // while a read is timed and its ack is still out, no second start
    a_start_gated: assert property (@(posedge ref_clk) disable iff (reset)
        busy && !stop |-> !start) else $error("start without ack");
    a_ack_cleared: assert property (@(posedge ref_clk) disable iff (reset)
        start |=> !ack_seen_q) else $error("ack history kept");
    a_stop_event: assert property (@(posedge ref_clk) disable iff (reset)
        stop |=> trace_event) else $error("no event on stop");
    a_same_next: assert property (@(posedge ref_clk) disable iff (reset || !prof_enable)
        state_q == srp_pkg::SRP_IDLE && start_same
        |=> state_q == srp_pkg::SRP_COUNT && cnt_q == srp_pkg::CNT_ZERO)
        else $error("same-cycle start late");
    // a queued read started by the previous ack waits one cycle
    a_alone_delay: assert property (@(posedge ref_clk) disable iff (reset || !prof_enable)
        start && !start_same |=> state_q == srp_pkg::SRP_HOLD)
        else $error("lone start not delayed");
    // the event raised by a stop is the one named by the final count
    a_event_index: assert property (@(posedge ref_clk) disable iff (reset)
        stop |=> ws_event[$past(cnt_q)]) else $error("wrong event index");
    a_queue_bound: assert property (@(posedge ref_clk) disable iff (reset)
        fill_q <= 3'h4) else $error("queue overflow");
    c_zero_wait: cover property (@(posedge ref_clk) ws_event[0]);
    c_max_wait:  cover property (@(posedge ref_clk) ws_event[7]);
    c_queue_full: cover property (@(posedge ref_clk) fill_q == 3'h3);
    c_hold_start: cover property (@(posedge ref_clk) state_q == srp_pkg::SRP_HOLD);
endmodule // srp_profiler
`default_nettype wire

/* rtl/srp_pkg.sv */
package srp_pkg;
    // request tracking depth and counter limits
    localparam int unsigned DEPTH      = 4;
    localparam int unsigned PTR_W      = 2;
    localparam int unsigned CNT_W      = 3;
    localparam logic [2:0]  CNT_MAX    = 3'h7;
    localparam logic [2:0]  CNT_ZERO   = 3'h0;
    localparam int unsigned N_EVENTS   = 8;
    localparam int unsigned N_BANKS    = 4;
    localparam int unsigned BANK_W     = 2;
    localparam int unsigned STAT_W     = 32;
    // bank mask resets to accept-all
    localparam logic [3:0]  BANK_MASK_RST = 4'hf;
    // profiler counter states
    typedef enum logic [1:0] {SRP_IDLE, SRP_HOLD, SRP_COUNT} srp_state_e;
endpackage

/* rtl/srp_stats.sv */
`timescale 1ns/1ps
`default_nettype none
// bank filter and statistics updater
module srp_stats (
    input  wire logic                      ref_clk,
    input  wire logic                      reset,
    input  wire logic                      ev_valid,
    input  wire logic [srp_pkg::CNT_W-1:0] ev_index,
    input  wire logic [srp_pkg::BANK_W-1:0] ev_bank,
    input  wire logic [srp_pkg::N_BANKS-1:0] bank_accept,
    input  wire logic                      clear_counts,
    output logic [srp_pkg::N_EVENTS*srp_pkg::STAT_W-1:0] ws_counts
);
    // bank decode shared by filter
    function automatic logic bank_ok(input logic [srp_pkg::N_BANKS-1:0] m,
                                     input logic [srp_pkg::BANK_W-1:0] b);
        bank_ok = m[b];
    endfunction

    wire logic accepted = ev_valid & bank_ok(bank_accept, ev_bank);

    // one 32-bit counter per wait-state event
    genvar g;
    generate
        for (g = 0; g < srp_pkg::N_EVENTS; g++) begin : g_cnt
            logic [srp_pkg::STAT_W-1:0] cnt_q;
            always_ff @(posedge ref_clk) begin
                if (reset || clear_counts) begin
                    cnt_q <= '0;
                end else if (accepted && ev_index == srp_pkg::CNT_W'(g)) begin
                    cnt_q <= cnt_q + 32'h1;
                end
            end
            assign ws_counts[g*srp_pkg::STAT_W +: srp_pkg::STAT_W] = cnt_q;
        end
    endgenerate
endmodule // srp_stats
`default_nettype wire

/* dv/srp_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
// level-2 side and shared-memory side of the port, behavioural
module srp_far_end (
    output logic       rd_req,    // read request
    output logic       req_stall, // request held at boundary
    output logic [1:0] req_bank,  // bank of request
    output logic       rd_ack     // read acknowledge
);
    int due_q[$];      // ack due cycle per accepted read, oldest first
    int now      = 0;  // own cycle count
    int last_ack = -10;
    initial begin
        rd_req    = 1'b0;
        req_stall = 1'b0;
        req_bank  = 2'h0;
        rd_ack    = 1'b0;
    end
    // one call per cycle just after the falling edge
    // acks kept off request cycles and two apart, so no decode/trigger overlap
    task automatic step(input logic want, input logic stall, input logic [1:0] bank,
                        input int lat);
        logic ack; // ack for this cycle, driven once at the end
        ack = 1'b0;
        now++;
        if (want && due_q.size() < 4) begin
            rd_req    = 1'b1;
            req_stall = stall;
            req_bank  = bank;
            if (!stall) due_q.push_back(now + lat);
        end else begin
            rd_req    = 1'b0;
            req_stall = 1'b0;
            req_bank  = ~req_bank; // released bus shows no stale bank
            if (due_q.size() > 0 && due_q[0] <= now && now - last_ack >= 2) begin
                ack = 1'b1;
                void'(due_q.pop_front());
                last_ack = now;
            end
        end
        rd_ack = ack;
    endtask
endmodule // srp_far_end
`default_nettype wire

/* dv/shared_memory_read_profiler_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fails++; \
    $display("unexpected %s exp %0h got %0h", n, e, s); end end
module shared_memory_read_profiler_test;
    logic ref_clk, reset, rd_req, req_stall, rd_ack, prof_enable, clear_counts;
    logic trace_event, busy;
    logic [1:0]   req_bank;
    logic [3:0]   bank_accept;
    logic [7:0]   ws_event;
    logic [255:0] ws_counts;
    logic [31:0]  cnt [8]; // expected statistics counters
    int fails = 0, cmp_count = 0, seed = 15, cyc = 0, last_ack = -100, ev_due = -1;
    int ev_idx, ev_bank, r, b, n;
    int req_q[$], bank_q[$]; // decoded reads awaiting their ack
    srp_far_end i_srp_far_end (.rd_req(rd_req), .req_stall(req_stall), .req_bank(req_bank),
                               .rd_ack(rd_ack));
    srp_profiler i_srp_profiler (.ref_clk(ref_clk), .reset(reset), .rd_req(rd_req),
        .req_stall(req_stall), .req_bank(req_bank), .rd_ack(rd_ack),
        .prof_enable(prof_enable), .clear_counts(clear_counts), .bank_accept(bank_accept),
        .trace_event(trace_event), .ws_event(ws_event), .busy(busy), .ws_counts(ws_counts));
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // wait states: start is request edge, or previous ack plus a hold cycle
    function automatic int exp_idx(int ack, int req, int prev);
        int v;
        v = ack - ((prev < req) ? req : prev) - 1 - ((prev >= req) ? 1 : 0);
        return (v > 7) ? 7 : ((v < 0) ? 0 : v);
    endfunction
    // port monitor: only sampled, never driven
    always @(posedge ref_clk) begin
        cyc++;
        if (prof_enable && rd_req && !req_stall) begin
            req_q.push_back(cyc);
            bank_q.push_back(req_bank);
        end
        if (prof_enable && rd_ack && req_q.size() > 0) begin
            r = req_q.pop_front();
            ev_bank = bank_q.pop_front();
            ev_idx = exp_idx(cyc, r, last_ack);
            ev_due = cyc; // event stands in the cycle after the ack edge
            last_ack = cyc;
        end
    end
    // event checks every cycle; no event when none is due
    always @(negedge ref_clk) if (!reset) begin
        `CHK("ws_event", (cyc == ev_due) ? (8'h01 << ev_idx) : 8'h00, ws_event)
        `CHK("trace_event", (cyc == ev_due), trace_event)
        `CHK("busy", req_q.size() != 0, busy)
        if (cyc == ev_due && bank_accept[ev_bank]) cnt[ev_idx] = cnt[ev_idx] + 1;
    end
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic step(input logic want, input int lat);
        i_srp_far_end.step(want, ($random(seed) % 8) == 0, 2'($random(seed)), lat);
        @(negedge ref_clk);
    endtask
    // idle until no read is outstanding and the counter is quiet
    task automatic drain;
        n = 0;
        while (i_srp_far_end.due_q.size() != 0 || busy !== 1'b0 || n < 4) begin
            step(1'b0, 1);
            n++;
            if (n > 300) begin
                fails++;
                $display("unexpected drain timeout");
                end_sim();
            end
        end
    endtask
    task automatic check_counts;
        for (int i = 0; i < 8; i++) `CHK("ws_counts", cnt[i], ws_counts[i*32 +: 32])
    endtask
    initial begin
        reset = 1'b1; prof_enable = 1'b0; clear_counts = 1'b0; bank_accept = 4'hf;
        for (int i = 0; i < 8; i++) cnt[i] = 32'h0;
        repeat (5) @(negedge ref_clk);
        reset = 1'b0;
        // disabled: traffic leaves no trace
        for (int i = 0; i < 30; i++) step(($random(seed) % 2) == 0, 3);
        drain();
        check_counts();
        prof_enable = 1'b1;
        // lone reads, every latency through saturation
        for (int l = 1; l <= 12; l++) begin
            step(1'b1, l);
            drain();
        end
        check_counts();
        // random back-to-back bursts, up to four outstanding, bank filtering
        for (int k = 0; k < 8; k++) begin
            bank_accept = 4'($random(seed));
            for (int i = 0; i < 60; i++)
                step(($random(seed) % 3) != 0, 1 + $unsigned($random(seed)) % 10);
            drain();
            check_counts();
        end
        clear_counts = 1'b1;
        @(negedge ref_clk);
        clear_counts = 1'b0;
        for (int i = 0; i < 8; i++) cnt[i] = 32'h0;
        @(negedge ref_clk);
        check_counts();
        `CHK("busy", 1'b0, busy)
        end_sim();
    end
endmodule // shared_memory_read_profiler_test
`default_nettype wire
